// File: pabo_defines.vh
`ifndef PABO_DEFINES_VH
`define PABO_DEFINES_VH
// pull-up pattern {direction, output bit, global disable}
`define PABO_PU_PATTERN   3'h2
`define PABO_PIN_SCK      7
`define PABO_PIN_MISO     6
`define PABO_PIN_MOSI     5
`define PABO_PIN_SS       4
`define PABO_PIN_OCA      3
`define PABO_PIN_AIN_NEG  3
`define PABO_PIN_AIN_POS  2
`define PABO_PIN_EXT2     2
`define PABO_PIN_DIVIDED_CLOCK_OUTPUT     1
`define PABO_PIN_T1       1
`define PABO_PIN_T0       0
`define PABO_PIN_XCK      0
`define PABO_RST_BYTE     8'h00
`endif

// File: pabo_pin_ctl.v
`timescale 1ns/1ps
// one pin: merges override signals with plain port register bits
module pabo_pin_ctl (
  input  wire pullup_override_enable,
  input  wire pullup_override_value,
  input  wire direction_override_enable,
  input  wire direction_override_value,
  input  wire value_override_enable,
  input  wire value_override_value,
  input  wire input_enable_override_enable,
  input  wire input_enable_override_value,
  input  wire dir_bit,
  input  wire out_bit,
  input  wire global_pullup_disable,
  input  wire sleep_active,
  output wire pullup_en,
  output wire drive_en,
  output wire drive_val,
  output wire input_en
);
`include "pabo_defines.vh"
  assign pullup_en = pullup_override_enable ? pullup_override_value :
                     ({dir_bit, out_bit, global_pullup_disable} == `PABO_PU_PATTERN); // (R19)
  assign drive_en  = direction_override_enable ? direction_override_value : dir_bit; // (R20)
  assign drive_val = (value_override_enable & drive_en) ? value_override_value : out_bit; // (R21)
  assign input_en  = input_enable_override_enable ? input_enable_override_value : ~sleep_active; // (R22)
endmodule // pabo_pin_ctl

// File: pabo_port_ab.v
`timescale 1ns/1ps
// Operation
// (R1) port A input enable from mask or adc disable
// (R2) port A pads feed converter channels
// (R3) port A inputs feed pin-change sources 7:0
// (R4) sck input when slave, else direction bit
// (R5) miso input when master, else direction bit
// (R6) mosi input when slave, else direction bit
// (R7) ss input when slave, else direction bit
// (R8) slave active only while ss low
// (R9) forced inputs keep pull-up from output bit
// (R10) compare B drives bit 4 when output
// (R11) compare A drives bit 3 when output
// (R12) bits 3,2 feed comparator negative, positive
// (R13) bit 2 input feeds external interrupt 2
// (R14) clock out fuse drives divided clock on bit1
// (R15) divided clock continues during reset; only clock_out_pin and port_b_drive_en do, port_b_drive_val is reset to 0
// (R16) port B maps to pin-change 15:8
// (R17) bit 1 input is timer1 count source
// (R18) bit 0 timer0 count and serial clock
// (R19) default pull-up only for pattern 010
// (R20) direction override selects driver enable
// (R21) value override drives when driver enabled
// (R22) input enable override versus sleep state
// (R23) overrides low while function disabled
module pabo_port_ab #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] port_a_direction_bits,
  input  wire [WIDTH-1:0] port_a_output_bits,
  input  wire [WIDTH-1:0] port_a_pad_in,
  input  wire [WIDTH-1:0] pin_change_mask_bit,
  input  wire             pin_change_group0_enable,
  input  wire [WIDTH-1:0] port_b_pin_change_mask,
  input  wire             pin_change_group1_enable,
  input  wire [WIDTH-1:0] adc_digital_input_disable,
  input  wire [WIDTH-1:0] port_b_direction_bits,
  input  wire [WIDTH-1:0] port_b_output_bits,
  input  wire [WIDTH-1:0] port_b_pad_in,
  input  wire             global_pullup_disable,
  input  wire             sleep_active,
  input  wire             spi_enable,
  input  wire             spi_master,
  input  wire             spi_sck_out,
  input  wire             spi_slave_out,
  input  wire             spi_master_out,
  input  wire             timer0_compare_a_output,
  input  wire             timer0_compare_a_enable,
  input  wire             timer0_compare_b_output,
  input  wire             timer0_compare_b_enable,
  input  wire             external_interrupt_2_enable,
  input  wire             clock_out_fuse,
  input  wire             divided_clock_output,
  output reg  [WIDTH-1:0] port_a_pullup_en,
  output reg  [WIDTH-1:0] port_a_drive_en,
  output reg  [WIDTH-1:0] port_a_drive_val,
  output reg  [WIDTH-1:0] port_a_input_en,
  output reg  [WIDTH-1:0] adc_channel_in,
  output reg  [WIDTH-1:0] pin_change_source,
  output reg  [WIDTH-1:0] port_b_pullup_en,
  output reg  [WIDTH-1:0] port_b_drive_en,
  output reg  [WIDTH-1:0] port_b_drive_val,
  output reg  [WIDTH-1:0] port_b_input_en,
  output reg  [WIDTH-1:0] pin_change_source_hi,
  output reg              spi_sck_in,
  output reg              spi_master_in,
  output reg              spi_slave_in,
  output reg              spi_slave_select,
  output reg              comparator_negative_input,
  output reg              comparator_positive_input,
  output reg              external_interrupt_2,
  output reg              timer1_count_input,
  output reg              timer0_count_input,
  output reg              serial_port_ext_clock,
  output reg              clock_out_pin
);
`include "pabo_defines.vh"

  wire [WIDTH-1:0] a_ie_oe;
  wire [WIDTH-1:0] a_ie_ov;
  wire [WIDTH-1:0] b_pu_oe;
  wire [WIDTH-1:0] b_pu_ov;
  wire [WIDTH-1:0] b_dd_oe;
  wire [WIDTH-1:0] b_dd_ov;
  wire [WIDTH-1:0] b_pv_oe;
  wire [WIDTH-1:0] b_pv_ov;
  wire [WIDTH-1:0] b_ie_oe;
  wire [WIDTH-1:0] b_ie_ov;
  wire [WIDTH-1:0] a_pu_d;
  wire [WIDTH-1:0] a_de_d;
  wire [WIDTH-1:0] a_dv_d;
  wire [WIDTH-1:0] a_ie_d;
  wire [WIDTH-1:0] b_pu_d;
  wire [WIDTH-1:0] b_de_d;
  wire [WIDTH-1:0] b_dv_d;
  wire [WIDTH-1:0] b_ie_d;
  wire             spi_as_master;
  wire             spi_as_slave;

  assign spi_as_master = spi_enable & spi_master; // (R23)
  assign spi_as_slave  = spi_enable & ~spi_master; // (R23)

  // port A: only the input enable is overridden
  assign a_ie_ov = pin_change_mask_bit & {WIDTH{pin_change_group0_enable}}; // (R1)
  assign a_ie_oe = a_ie_ov | adc_digital_input_disable; // (R1)

  // port B pull-up: forced inputs keep pull-up from output bit unless disabled globally
  assign b_pu_oe = {{4{spi_enable}}, 4'h0}; // (R23)
  assign b_pu_ov = {{4{spi_enable}}, 4'h0} & port_b_output_bits & {WIDTH{~global_pullup_disable}}; // (R9)

  // port B direction override; SPI pins force input (enable=1 value=0), bit 1 forces output (value=clock_out_fuse)
  assign b_dd_oe[`PABO_PIN_SCK]  = spi_as_slave; // (R4)
  assign b_dd_oe[`PABO_PIN_MISO] = spi_as_master; // (R5)
  assign b_dd_oe[`PABO_PIN_MOSI] = spi_as_slave; // (R6)
  assign b_dd_oe[`PABO_PIN_SS]   = spi_as_slave; // (R7)
  assign b_dd_oe[`PABO_PIN_OCA]  = 1'b0;
  assign b_dd_oe[`PABO_PIN_EXT2] = 1'b0;
  assign b_dd_oe[`PABO_PIN_DIVIDED_CLOCK_OUTPUT] = clock_out_fuse; // (R14)
  assign b_dd_oe[`PABO_PIN_T0]   = 1'b0;
  assign b_dd_ov = {{4{1'b0}}, 2'h0, clock_out_fuse, 1'b0}; // (R14)

  // port B value override; compare outputs reach pad only via direction bit
  assign b_pv_oe[`PABO_PIN_SCK]  = spi_as_master;
  assign b_pv_oe[`PABO_PIN_MISO] = spi_as_slave;
  assign b_pv_oe[`PABO_PIN_MOSI] = spi_as_master;
  assign b_pv_oe[`PABO_PIN_SS]   = timer0_compare_b_enable; // (R10)
  assign b_pv_oe[`PABO_PIN_OCA]  = timer0_compare_a_enable; // (R11)
  assign b_pv_oe[`PABO_PIN_EXT2] = 1'b0;
  assign b_pv_oe[`PABO_PIN_DIVIDED_CLOCK_OUTPUT] = clock_out_fuse; // (R14)
  assign b_pv_oe[`PABO_PIN_T0]   = 1'b0;
  assign b_pv_ov = {spi_sck_out, spi_slave_out, spi_master_out, timer0_compare_b_output,
                    timer0_compare_a_output, 1'b0, divided_clock_output, 1'b0};

  assign b_ie_ov = {WIDTH{1'b1}};
  assign b_ie_oe = (port_b_pin_change_mask & {WIDTH{pin_change_group1_enable}}) |
                   {5'h00, external_interrupt_2_enable, 2'h0}; // (R13)

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      pabo_pin_ctl u_a (
        .pullup_override_enable      (1'b0),
        .pullup_override_value       (1'b0),
        .direction_override_enable   (1'b0),
        .direction_override_value    (1'b0),
        .value_override_enable       (1'b0),
        .value_override_value        (1'b0),
        .input_enable_override_enable(a_ie_oe[g]),
        .input_enable_override_value (a_ie_ov[g]),
        .dir_bit                     (port_a_direction_bits[g]),
        .out_bit                     (port_a_output_bits[g]),
        .global_pullup_disable       (global_pullup_disable),
        .sleep_active                (sleep_active),
        .pullup_en                   (a_pu_d[g]),
        .drive_en                    (a_de_d[g]),
        .drive_val                   (a_dv_d[g]),
        .input_en                    (a_ie_d[g])
      );
      pabo_pin_ctl u_b (
        .pullup_override_enable      (b_pu_oe[g]),
        .pullup_override_value       (b_pu_ov[g]),
        .direction_override_enable   (b_dd_oe[g]),
        .direction_override_value    (b_dd_ov[g]),
        .value_override_enable       (b_pv_oe[g]),
        .value_override_value        (b_pv_ov[g]),
        .input_enable_override_enable(b_ie_oe[g]),
        .input_enable_override_value (b_ie_ov[g]),
        .dir_bit                     (port_b_direction_bits[g]),
        .out_bit                     (port_b_output_bits[g]),
        .global_pullup_disable       (global_pullup_disable),
        .sleep_active                (sleep_active),
        .pullup_en                   (b_pu_d[g]),
        .drive_en                    (b_de_d[g]),
        .drive_val                   (b_dv_d[g]),
        .input_en                    (b_ie_d[g])
      );
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      port_a_pullup_en          <= `PABO_RST_BYTE;
      port_a_drive_en           <= `PABO_RST_BYTE;
      port_a_drive_val          <= `PABO_RST_BYTE;
      port_a_input_en           <= `PABO_RST_BYTE;
      adc_channel_in            <= `PABO_RST_BYTE;
      pin_change_source         <= `PABO_RST_BYTE;
      port_b_pullup_en          <= `PABO_RST_BYTE;
      port_b_drive_val          <= `PABO_RST_BYTE;
      port_b_input_en           <= `PABO_RST_BYTE;
      pin_change_source_hi      <= `PABO_RST_BYTE;
      spi_sck_in                <= 1'b0;
      spi_master_in             <= 1'b0;
      spi_slave_in              <= 1'b0;
      spi_slave_select          <= 1'b1;
      comparator_negative_input <= 1'b0;
      comparator_positive_input <= 1'b0;
      external_interrupt_2      <= 1'b0;
      timer1_count_input        <= 1'b0;
      timer0_count_input        <= 1'b0;
      serial_port_ext_clock     <= 1'b0;
    end else begin
      port_a_pullup_en          <= a_pu_d;
      port_a_drive_en           <= a_de_d;
      port_a_drive_val          <= a_dv_d;
      port_a_input_en           <= a_ie_d;
      adc_channel_in            <= port_a_pad_in; // (R2)
      pin_change_source         <= port_a_pad_in; // (R3)
      port_b_pullup_en          <= b_pu_d; // (R9)
      port_b_drive_val          <= b_dv_d;
      port_b_input_en           <= b_ie_d;
      pin_change_source_hi      <= port_b_pad_in; // (R16)
      spi_sck_in                <= port_b_pad_in[`PABO_PIN_SCK];
      spi_master_in             <= port_b_pad_in[`PABO_PIN_MISO];
      spi_slave_in              <= port_b_pad_in[`PABO_PIN_MOSI];
      // slave logic treats low as selected; high when not slave keeps it idle
      spi_slave_select          <= ~spi_as_slave | port_b_pad_in[`PABO_PIN_SS]; // (R8)
      comparator_negative_input <= port_b_pad_in[`PABO_PIN_AIN_NEG]; // (R12)
      comparator_positive_input <= port_b_pad_in[`PABO_PIN_AIN_POS]; // (R12)
      external_interrupt_2      <= port_b_pad_in[`PABO_PIN_EXT2]; // (R13)
      timer1_count_input        <= port_b_pad_in[`PABO_PIN_T1]; // (R17)
      timer0_count_input        <= port_b_pad_in[`PABO_PIN_T0]; // (R18)
      serial_port_ext_clock     <= port_b_pad_in[`PABO_PIN_XCK]; // (R18)
    end
  end

  // clock pin and its driver enable keep running through reset
  always @(posedge clk_sys) begin
    port_b_drive_en <= b_de_d; // (R15)
    clock_out_pin   <= clock_out_fuse & divided_clock_output; // (R15)
  end
endmodule // pabo_port_ab

// File: pabo_port_ab_monitor.sv
`timescale 1ns/1ps
module pabo_port_ab_monitor (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       pin_change_group0_enable,
  input wire       pin_change_group1_enable,
  input wire       global_pullup_disable,
  input wire       sleep_active,
  input wire       spi_enable,
  input wire       spi_master,
  input wire       timer0_compare_a_output,
  input wire       timer0_compare_a_enable,
  input wire       external_interrupt_2_enable,
  input wire       clock_out_fuse,
  input wire       divided_clock_output,
  input wire       spi_slave_select,
  input wire       clock_out_pin,
  input wire [7:0] port_a_direction_bits,
  input wire [7:0] port_a_pad_in,
  input wire [7:0] pin_change_mask_bit,
  input wire [7:0] adc_digital_input_disable,
  input wire [7:0] port_b_pin_change_mask,
  input wire [7:0] port_b_direction_bits,
  input wire [7:0] port_b_output_bits,
  input wire [7:0] port_b_pad_in,
  input wire [7:0] port_a_input_en,
  input wire [7:0] port_a_drive_en,
  input wire [7:0] adc_channel_in,
  input wire [7:0] pin_change_source,
  input wire [7:0] port_b_pullup_en,
  input wire [7:0] port_b_drive_en,
  input wire [7:0] port_b_drive_val,
  input wire [7:0] port_b_input_en,
  input wire [7:0] pin_change_source_hi
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire       sl = spi_enable & ~spi_master;
  wire       ms = spi_enable & spi_master;
  wire [7:0] m0 = pin_change_mask_bit & {8{pin_change_group0_enable}};
  wire [7:0] a_ie = m0 | (~adc_digital_input_disable & {8{~sleep_active}});
  wire [3:0] spi_de = port_b_direction_bits[7:4] & ~{sl, ms, sl, sl};
  wire [7:0] pu = port_b_output_bits & {8{~global_pullup_disable}} &
                  ({{4{spi_enable}}, 4'h0} | ~port_b_direction_bits);
  wire [7:0] b_oe = (port_b_pin_change_mask & {8{pin_change_group1_enable}}) |
                    {5'h0, external_interrupt_2_enable, 2'h0};
  wire       v3 = (timer0_compare_a_enable & port_b_direction_bits[3]) ?
                  timer0_compare_a_output : port_b_output_bits[3];
  // outputs registered: only judge edges whose previous edge was out of reset
  sequence s_run; $past(rst_n); endsequence
  property p_a_ie; s_run |-> port_a_input_en == $past(a_ie); endproperty
  a_a_ie: assert property (p_a_ie) else $error("port a input enable wrong");
  property p_a_drv; s_run |-> port_a_drive_en == $past(port_a_direction_bits); endproperty
  a_a_drv: assert property (p_a_drv) else $error("port a driver enable wrong");
  property p_a_map;
    s_run |-> adc_channel_in == $past(port_a_pad_in) && pin_change_source == $past(port_a_pad_in);
  endproperty
  a_a_map: assert property (p_a_map) else $error("port a pad routing wrong");
  property p_b_map; s_run |-> pin_change_source_hi == $past(port_b_pad_in); endproperty
  a_b_map: assert property (p_b_map) else $error("port b pin change routing wrong");
  property p_spi_dir; s_run |-> port_b_drive_en[7:4] == $past(spi_de); endproperty
  a_spi_dir: assert property (p_spi_dir) else $error("spi pin direction wrong");
  property p_pull; s_run |-> port_b_pullup_en == $past(pu); endproperty
  a_pull: assert property (p_pull) else $error("port b pull-up wrong");
  property p_oca; s_run |-> port_b_drive_val[3] == $past(v3); endproperty
  a_oca: assert property (p_oca) else $error("compare a pin value wrong");
  property p_ss; s_run |-> spi_slave_select == ($past(sl) ? $past(port_b_pad_in[4]) : 1'b1); endproperty
  a_ss: assert property (p_ss) else $error("slave select wrong");
  property p_clk; s_run |-> clock_out_pin == $past(clock_out_fuse & divided_clock_output)
    && port_b_drive_en[1] == $past(clock_out_fuse | port_b_direction_bits[1]); endproperty
  a_clk: assert property (p_clk) else $error("clock output pin wrong");
  property p_b_ie; s_run |-> port_b_input_en == $past(b_oe | {8{~sleep_active}}); endproperty
  a_b_ie: assert property (p_b_ie) else $error("port b input enable wrong");
endmodule // pabo_port_ab_monitor
bind pabo_port_ab pabo_port_ab_monitor u_mon (.*);

// File: pabo_pad_model.sv
`timescale 1ns/1ps
module pabo_pad_model (
  input  wire       clk_sys,
  input  wire [7:0] drive_en,
  input  wire [7:0] drive_val,
  input  wire [7:0] pullup_en,
  input  wire [7:0] ext_en,
  input  wire [7:0] ext_val,
  output wire [7:0] pad
);
  reg [7:0] float_q = 8'h55;
  // floating pin toggles so a stale level never passes for a driven one
  always @(posedge clk_sys) float_q <= ~float_q;
  assign pad = (drive_en & drive_val) | (~drive_en & ext_en & ext_val) | (~drive_en & ~ext_en & (pullup_en | float_q));
endmodule // pabo_pad_model

// File: pabo_port_ab_tb.sv
`timescale 1ns/1ps
module pabo_port_ab_tb;
  logic clk_sys, rst_n, pin_change_group0_enable, pin_change_group1_enable, global_pullup_disable, sleep_active;
  logic spi_enable, spi_master, spi_sck_out, spi_slave_out, spi_master_out, timer0_compare_a_output;
  logic timer0_compare_a_enable, timer0_compare_b_output, timer0_compare_b_enable, external_interrupt_2_enable;
  logic clock_out_fuse, divided_clock_output;
  logic [7:0] port_a_direction_bits, port_a_output_bits, port_a_pad_in, pin_change_mask_bit, ext_en, ext_val;
  logic [7:0] port_b_pin_change_mask, adc_digital_input_disable, port_b_direction_bits, port_b_output_bits;
  wire  [7:0] port_a_pullup_en, port_a_drive_en, port_a_drive_val, port_a_input_en, adc_channel_in, port_b_pad_in;
  wire  [7:0] pin_change_source, port_b_pullup_en, port_b_drive_en, port_b_drive_val, port_b_input_en;
  wire  [7:0] pin_change_source_hi;
  wire        spi_sck_in, spi_master_in, spi_slave_in, spi_slave_select, comparator_negative_input;
  wire        comparator_positive_input, external_interrupt_2, timer1_count_input, timer0_count_input;
  wire        serial_port_ext_clock, clock_out_pin;
  integer     failures = 0, comparisons = 0, i;
  pabo_port_ab uut (.*);
  pabo_pad_model u_pads (.clk_sys(clk_sys), .drive_en(port_b_drive_en), .drive_val(port_b_drive_val),
    .pullup_en(port_b_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad(port_b_pad_in));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) divided_clock_output <= ~divided_clock_output;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs already set after a falling edge; look once the rising edge has landed
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task t_port_a;
    {pin_change_mask_bit, pin_change_group0_enable, adc_digital_input_disable} = {8'ha5, 1'b1, 8'h3c};
    {sleep_active, port_a_direction_bits, port_a_output_bits, port_a_pad_in} = {1'b1, 8'h0f, 8'hf0, 8'h96};
    step;
    chk(port_a_input_en, 8'ha5);
    chk(port_a_drive_en, 8'h0f);
    chk(port_a_pullup_en, 8'hf0);
    chk(port_a_drive_val, 8'hf0);
    chk(adc_channel_in, 8'h96);
    chk(pin_change_source, 8'h96);
    @(negedge clk_sys);
    {sleep_active, pin_change_group0_enable, global_pullup_disable} = 3'h1;
    step;
    chk(port_a_input_en, 8'hc3);
    chk(port_a_pullup_en, 8'h00);
    @(negedge clk_sys);
    global_pullup_disable = 0;
  endtask
  task t_spi;
    for (i = 0; i < 2; i = i + 1) begin
      @(negedge clk_sys);
      {spi_enable, spi_master, port_b_direction_bits, port_b_output_bits} = {1'b1, i[0], 8'hf0, 8'hf0};
      step;
      chk(port_b_drive_en & 8'hf0, i ? 8'hb0 : 8'h40);
      chk(port_b_pullup_en & 8'hf0, 8'hf0);
      chk(port_b_drive_val & 8'hf0, i ? 8'h50 : 8'hb0);
    end
    @(negedge clk_sys);
    spi_enable = 0;
    step;
    chk(port_b_drive_en & 8'hf0, 8'hf0);
    chk(port_b_pullup_en & 8'hf0, 8'h00);
  endtask
  task t_ss;
    @(negedge clk_sys);
    {spi_enable, spi_master, port_b_direction_bits, ext_en, ext_val} = {2'b10, 8'h00, 8'h10, 8'h00};
    // the pad only lets go once the registered driver enable has dropped
    @(posedge clk_sys);
    step;
    chk(spi_slave_select, 1'b0);
    @(negedge clk_sys);
    ext_val = 8'h10;
    step;
    chk(spi_slave_select, 1'b1);
    @(negedge clk_sys);
    {spi_master, ext_val} = {1'b1, 8'h00};
    step;
    chk(spi_slave_select, 1'b1);
    @(negedge clk_sys);
    {spi_enable, ext_en} = 0;
  endtask
  task t_timer;
    @(negedge clk_sys);
    {timer0_compare_a_output, timer0_compare_a_enable, timer0_compare_b_output, timer0_compare_b_enable} = 4'hf;
    {port_b_direction_bits, port_b_output_bits} = {8'h18, 8'h00};
    step;
    chk(port_b_drive_val & 8'h18, 8'h18);
    @(negedge clk_sys);
    port_b_direction_bits = 8'h00;
    step;
    chk(port_b_drive_val & 8'h18, 8'h00);
  endtask
  task t_map(input logic [7:0] v, input logic [7:0] exp);
    @(negedge clk_sys);
    {ext_en, ext_val, port_b_pin_change_mask, pin_change_group1_enable} = {8'hff, v, 8'h09, 1'b1};
    {external_interrupt_2_enable, sleep_active} = 2'b11;
    step;
    chk(pin_change_source_hi, v);
    chk({comparator_negative_input, comparator_positive_input, external_interrupt_2, timer1_count_input,
         timer0_count_input, serial_port_ext_clock, 2'b00}, exp);
    chk(port_b_input_en, 8'h0d);
    chk({5'h00, spi_sck_in, spi_master_in, spi_slave_in}, {5'h00, v[7:5]});
    @(negedge clk_sys);
    {ext_en, sleep_active} = 0;
  endtask
  task t_clk;
    @(negedge clk_sys);
    clock_out_fuse = 1;
    step;
    chk(clock_out_pin, divided_clock_output);
    chk(port_b_drive_en & 8'h02, 8'h02);
    chk(port_b_drive_val & 8'h02, {6'h00, divided_clock_output, 1'b0});
    @(negedge clk_sys);
    rst_n = 0;
    repeat (2) begin
      step;
      chk(clock_out_pin, divided_clock_output);
      chk(port_b_drive_en & 8'h02, 8'h02);
    end
    @(negedge clk_sys);
    {rst_n, clock_out_fuse} = 2'b10;
    step;
    chk(clock_out_pin, 1'b0);
  endtask
  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {pin_change_group0_enable, pin_change_group1_enable, global_pullup_disable, sleep_active} = 0;
    {spi_enable, spi_master, spi_sck_out, spi_slave_out, spi_master_out, timer0_compare_a_output} = 0;
    {timer0_compare_a_enable, timer0_compare_b_output, timer0_compare_b_enable, external_interrupt_2_enable} = 0;
    {clock_out_fuse, divided_clock_output, rst_n, ext_en, ext_val} = 0;
    {port_a_direction_bits, port_a_output_bits, port_a_pad_in, pin_change_mask_bit} = 0;
    {port_b_pin_change_mask, adc_digital_input_disable, port_b_direction_bits, port_b_output_bits} = 0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    t_port_a;
    t_spi;
    t_ss;
    t_timer;
    t_map(8'h5a, 8'h90);
    t_map(8'ha5, 8'h6c);
    t_clk;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures = failures + 1;
    print_verdict;
  end
endmodule // pabo_port_ab_tb
